// ---- verilog/lvp_pkg.sv ----
// Constants and types for the linefeed voltage and power register bank
package lvp_pkg;

  // Register addresses on the control port
  localparam logic [7:0] LVP_ADDR_ONHOOK   = 8'h48;
  localparam logic [7:0] LVP_ADDR_CMODE    = 8'h49;
  localparam logic [7:0] LVP_ADDR_HBAT     = 8'h4A;
  localparam logic [7:0] LVP_ADDR_LBAT     = 8'h4B;
  localparam logic [7:0] LVP_ADDR_PSEL     = 8'h4C;
  localparam logic [7:0] LVP_ADDR_PRESULT  = 8'h4D;

  // Field layout
  localparam int         LVP_LEVEL_W       = 6;
  localparam int         LVP_POLARITY_BIT  = 6;
  localparam int         LVP_PSEL_W        = 3;
  localparam int         LVP_POWER_W       = 8;

  // Reset values (level codes in 1.5 V steps)
  localparam logic [5:0] LVP_RST_ONHOOK    = 6'h20;
  localparam logic       LVP_RST_POLARITY  = 1'h0;
  localparam logic [5:0] LVP_RST_CMODE     = 6'h02;
  localparam logic [5:0] LVP_RST_HBAT      = 6'h32;
  localparam logic [5:0] LVP_RST_LBAT      = 6'h10;
  localparam logic [2:0] LVP_RST_PSEL      = 3'h0;
  localparam logic [7:0] LVP_RST_BYTE      = 8'h00;

  // Scales of the codes, for reference by software and bench
  localparam int         LVP_LEVEL_STEP_MV = 1500;
  localparam int         LVP_COARSE_UW     = 30400;
  localparam int         LVP_FINE_UW       = 3620;

  // Transistor codes with the fine power scale
  localparam logic [2:0] LVP_Q3            = 3'h2;
  localparam logic [2:0] LVP_Q4            = 3'h3;

  // Setpoints driven toward the analog linefeed
  typedef struct packed {
    logic       diff_manual;
    logic       diff_negative;
    logic [5:0] diff_level;
    logic       tip_cm_manual;
    logic       ring_cm_manual;
    logic [5:0] cm_level;
    logic [5:0] high_battery_level;
    logic [5:0] low_battery_level;
    logic       battery_floor_en;
    logic       power_fine_scale;
  } lvp_drive_type;

  // Complete register state of the bank
  typedef struct packed {
    logic [5:0]    onhook_voltage_level;
    logic          onhook_polarity;
    logic [5:0]    common_mode_level;
    logic [5:0]    high_battery_level;
    logic [5:0]    low_battery_level;
    logic [2:0]    power_monitor_select;
    logic [7:0]    power_monitor_result;
    logic [7:0]    rdata;
    logic          rvalid;
    lvp_drive_type drive;
  } lvp_state_type;

endpackage

// ---- verilog/lvp_regs.sv ----
// Linefeed voltage settings and transistor power monitor register bank
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Six-bit on-hook magnitude, 1.5 V steps, 48 V
// - Bit 6 picks on-hook voltage sign
// - Common mode on tip forward, ring reverse
// - Common-mode code in -1.5 V steps, -3 V
// - High battery code in 1.5 V steps, -75 V
// - Low battery code in 1.5 V steps, -24 V
// - Select codes 0..5 pick Q1..Q6 transistors
// - Result register shows selected power live
// - Q1 Q2 Q5 Q6 use coarse power scale
// - Q3 Q4 use fine power scale
// - Manual differential follows on-hook setting
// - Manual common mode drives tip or ring
// - Battery floor at low level unless tracking
module lvp_regs
  import lvp_pkg::*;
#(
  parameter int NUM_TRANSISTORS = 6
)(
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_write_in,
  input  wire logic                   reg_read_in,
  output logic      [7:0]             reg_rdata_out,
  output logic                        reg_rvalid_out,
  input  wire logic [NUM_TRANSISTORS*LVP_POWER_W-1:0] power_sample_in,
  input  wire logic                   line_reverse_in,
  input  wire logic                   line_cm_state_in,
  input  wire logic                   manual_differential_select_in,
  input  wire logic                   manual_common_mode_select_in,
  input  wire logic                   battery_tracking_in,
  output lvp_drive_type               drive_out
);

  if (NUM_TRANSISTORS < 1 || NUM_TRANSISTORS > 8)
  begin : g_bad_count
    $error("NUM_TRANSISTORS must lie between 1 and 8");
  end

  lvp_state_type state;
  lvp_state_type next_state;
  logic [7:0]    power_chain [NUM_TRANSISTORS+1];
  logic [7:0]    read_value;

  // Mux of the live power samples, one stage per transistor
  assign power_chain[0] = LVP_RST_BYTE;
  for (genvar i = 0; i < NUM_TRANSISTORS; i++)
  begin : g_power_sel
    localparam logic [2:0] CODE = 3'(i);
    assign power_chain[i+1] = power_chain[i] |
      ((state.power_monitor_select == CODE) ?
       power_sample_in[i*LVP_POWER_W +: LVP_POWER_W] : LVP_RST_BYTE);
  end

  // Read decode
  always_comb
  begin
    case (reg_addr_in)
      LVP_ADDR_ONHOOK:
        read_value = {1'h0, state.onhook_polarity,
                      state.onhook_voltage_level};
      LVP_ADDR_CMODE:
        read_value = {2'h0, state.common_mode_level};
      LVP_ADDR_HBAT:
        read_value = {2'h0, state.high_battery_level};
      LVP_ADDR_LBAT:
        read_value = {2'h0, state.low_battery_level};
      LVP_ADDR_PSEL:
        read_value = {5'h00, state.power_monitor_select};
      LVP_ADDR_PRESULT:
        read_value = state.power_monitor_result;
      default:
        read_value = LVP_RST_BYTE;
    endcase
  end

  // Next state
  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'h0;
    if (reg_read_in)
    begin
      next_state.rdata  = read_value;
      next_state.rvalid = 1'h1;
    end
    if (reg_write_in)
    begin
      case (reg_addr_in)
        LVP_ADDR_ONHOOK:
        begin
          next_state.onhook_voltage_level =
            reg_wdata_in[LVP_LEVEL_W-1:0];
          next_state.onhook_polarity =
            reg_wdata_in[LVP_POLARITY_BIT];
        end
        LVP_ADDR_CMODE:
          next_state.common_mode_level =
            reg_wdata_in[LVP_LEVEL_W-1:0];
        LVP_ADDR_HBAT:
          next_state.high_battery_level =
            reg_wdata_in[LVP_LEVEL_W-1:0];
        LVP_ADDR_LBAT:
          next_state.low_battery_level =
            reg_wdata_in[LVP_LEVEL_W-1:0];
        LVP_ADDR_PSEL:
          next_state.power_monitor_select =
            reg_wdata_in[LVP_PSEL_W-1:0];
        default:
          next_state.rvalid = next_state.rvalid;
      endcase
    end

    // Live power result, refreshed every enabled cycle
    next_state.power_monitor_result = power_chain[NUM_TRANSISTORS];

    // Setpoints toward the linefeed, from the updated registers
    next_state.drive.diff_manual   = manual_differential_select_in;
    next_state.drive.diff_level    = next_state.onhook_voltage_level;
    next_state.drive.diff_negative = next_state.onhook_polarity;
    next_state.drive.tip_cm_manual = manual_common_mode_select_in &
      line_cm_state_in & ~line_reverse_in;
    next_state.drive.ring_cm_manual = manual_common_mode_select_in &
      line_cm_state_in & line_reverse_in;
    next_state.drive.cm_level      = next_state.common_mode_level;
    next_state.drive.high_battery_level = next_state.high_battery_level;
    next_state.drive.low_battery_level  = next_state.low_battery_level;
    next_state.drive.battery_floor_en   = ~battery_tracking_in;
    next_state.drive.power_fine_scale =
      (next_state.power_monitor_select == LVP_Q3) ||
      (next_state.power_monitor_select == LVP_Q4);
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state.onhook_voltage_level <= LVP_RST_ONHOOK;
      state.onhook_polarity      <= LVP_RST_POLARITY;
      state.common_mode_level    <= LVP_RST_CMODE;
      state.high_battery_level   <= LVP_RST_HBAT;
      state.low_battery_level    <= LVP_RST_LBAT;
      state.power_monitor_select <= LVP_RST_PSEL;
      state.power_monitor_result <= LVP_RST_BYTE;
      state.rdata                <= LVP_RST_BYTE;
      state.rvalid               <= 1'h0;
      state.drive                <= '{
        diff_manual:        1'h0,
        diff_negative:      LVP_RST_POLARITY,
        diff_level:         LVP_RST_ONHOOK,
        tip_cm_manual:      1'h0,
        ring_cm_manual:     1'h0,
        cm_level:           LVP_RST_CMODE,
        high_battery_level: LVP_RST_HBAT,
        low_battery_level:  LVP_RST_LBAT,
        battery_floor_en:   1'h1,
        power_fine_scale:   1'h0
      };
    end
    else if (ce_in)
    begin
      state <= next_state;
    end
  end

  assign reg_rdata_out  = state.rdata;
  assign reg_rvalid_out = state.rvalid;
  assign drive_out      = state.drive;

endmodule // lvp_regs

`default_nettype wire

// ---- dv/lvp_regs_assertions.sv ----
// Port checker of the linefeed voltage and power registers
`timescale 1ns/1ps
`default_nettype none
module lvp_regs_checker
  import lvp_pkg::*;
#(parameter int NUM_TRANSISTORS = 6)
(
  input wire logic                   clock_in,
  input wire logic                   rst_in,
  input wire logic                   ce_in,
  input wire logic [7:0]             reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic                   reg_write_in,
  input wire logic                   reg_read_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   reg_rvalid_out,
  input wire logic [NUM_TRANSISTORS*LVP_POWER_W-1:0] power_sample_in,
  input wire logic                   line_reverse_in,
  input wire logic                   line_cm_state_in,
  input wire logic                   manual_differential_select_in,
  input wire logic                   manual_common_mode_select_in,
  input wire logic                   battery_tracking_in,
  input wire lvp_drive_type          drive_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(a);
    ce_in && reg_read_in && !reg_write_in && reg_addr_in == a;
  endsequence
  sequence s_wr(a);
    ce_in && reg_write_in && reg_addr_in == a;
  endsequence
  AST_RVALID:
    assert property (ce_in && reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  AST_ONHOOK:
    assert property (s_rd(LVP_ADDR_ONHOOK) |=> reg_rdata_out ==
      {1'b0, drive_out.diff_negative, drive_out.diff_level})
    else $error("on-hook read differs from drive");
  AST_RSVD:
    assert property (s_rd(LVP_ADDR_PSEL) |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved select bits not zero");
  AST_HBAT:
    assert property (s_wr(LVP_ADDR_HBAT) |=>
      drive_out.high_battery_level == $past(reg_wdata_in[5:0]))
    else $error("high battery not updated");
  AST_TIP:
    assert property (ce_in |=> drive_out.tip_cm_manual == $past(
      manual_common_mode_select_in && line_cm_state_in && !line_reverse_in))
    else $error("tip common mode drive wrong");
  AST_RING:
    assert property (ce_in |=> drive_out.ring_cm_manual == $past(
      manual_common_mode_select_in && line_cm_state_in && line_reverse_in))
    else $error("ring common mode drive wrong");
  AST_FLOOR:
    assert property (ce_in |=>
      drive_out.battery_floor_en == !$past(battery_tracking_in))
    else $error("battery floor wrong");
  AST_FINE:
    assert property (s_wr(LVP_ADDR_PSEL) |=>
      drive_out.power_fine_scale == ($past(reg_wdata_in[2:1]) == 2'h1))
    else $error("power scale wrong");
endmodule // lvp_regs_checker
bind lvp_regs lvp_regs_checker #(.NUM_TRANSISTORS(NUM_TRANSISTORS)) u_chk (.*);
`default_nettype wire

// ---- dv/test_lvp_regs.sv ----
// Self-checking bench of the linefeed voltage and power registers
`timescale 1ns/1ps
`default_nettype none
module test_lvp_regs;
  import lvp_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rv, rev = 0, cms = 0, md = 0;
  logic mc = 0, trk = 0, ce = 1;
  logic [7:0] adr = 0, wd = 0, rdat;
  logic [47:0] smp = 0;
  lvp_drive_type drv;
  int n_mismatch = 0, checks = 0;
  int mdl [6] = '{8'h20, 8'h02, 8'h32, 8'h10, 0, 0};
  int msk [6] = '{8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h07, 0};
  lvp_regs i_dut (.clock_in(clk), .rst_in(rst), .ce_in(ce),
    .reg_addr_in(adr), .reg_wdata_in(wd), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .power_sample_in(smp), .line_reverse_in(rev), .line_cm_state_in(cms),
    .manual_differential_select_in(md), .manual_common_mode_select_in(mc),
    .battery_tracking_in(trk), .drive_out(drv));
  task automatic chk(input logic [63:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    if (a inside {[8'h48:8'h4C]}) mdl[a-8'h48] = d & msk[a-8'h48];
  endtask
  function automatic logic [7:0] exp_of(logic [7:0] a);
    if (a == 8'h4D) return mdl[4] < 6 ? smp[mdl[4]*8 +: 8] : 8'h00;
    return a inside {[8'h48:8'h4C]} ? 8'(mdl[a-8'h48]) : 8'h00;
  endfunction
  function automatic lvp_drive_type exp_drv();
    return '{md, mdl[0][6], mdl[0][5:0], mc & cms & !rev, mc & cms & rev,
      mdl[1][5:0], mdl[2][5:0], mdl[3][5:0], !trk, mdl[4] inside {2, 3}};
  endfunction
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rv, 1);
    chk(rdat, exp_of(a));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(32'hCC90));
    repeat (20) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) rdr(8'h48 + i);
    $display("done: reset values");
    repeat (40)
    begin
      a = 8'h48 + 8'($urandom % 8);
      d = 8'($urandom);
      if (a == 8'h4A && d[5:0] < mdl[3][5:0]) d[5:0] = mdl[3][5:0];
      if (a == 8'h4B && d[5:0] > mdl[2][5:0]) d[5:0] = mdl[2][5:0];
      wrr(a, d);
      rdr(a);
    end
    $display("done: write and read back");
    @(posedge clk);
    ce <= 0;
    adr <= 8'h48;
    wd <= 8'h55;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    ce <= 1;
    rdr(8'h48);
    $display("done: clock enable freeze");
    for (int s = 0; s < 8; s++)
    begin
      wrr(8'h4C, s);
      smp <= 48'({$urandom, $urandom});
      rdr(8'h4D);
      chk(drv, exp_drv());
    end
    $display("done: power monitor");
    repeat (40)
    begin
      @(posedge clk);
      {rev, cms, md, mc, trk} <= 5'($urandom);
      @(posedge clk);
      #1 chk(drv, exp_drv());
    end
    $display("done: line drive");
    final_report();
  end
endmodule // test_lvp_regs
`default_nettype wire
